/* common/scpm_pkg.sv */
// package: register offsets, field layouts and reset values for clock control
package scpm_pkg;
    localparam logic [7:0] PWR_CTRL_ADDR   = 8'h87;
    localparam logic [7:0] CLK_SEL_ADDR    = 8'hA9;
    localparam logic [7:0] HF_CTRL_ADDR    = 8'hB2;
    localparam logic [7:0] HF_CAL_ADDR     = 8'hB3;
    localparam int         PWR_IDLE_BIT    = 0;
    localparam int         PWR_STOP_BIT    = 1;
    localparam int         HF_EN_BIT       = 7;
    localparam int         HF_RDY_BIT      = 6;
    localparam int         HF_SUSP_BIT     = 5;
    localparam logic [5:0] SCRATCH_RST     = 6'h00;
    localparam logic [1:0] SRC_HF          = 2'h0;
    localparam logic [1:0] SRC_EXT         = 2'h1;
    localparam logic [1:0] SRC_LF          = 2'h2;
    localparam logic [1:0] SRC_RST         = 2'h0;
    localparam logic [1:0] DIV_BY8         = 2'h0;
    localparam logic [1:0] DIV_BY4         = 2'h1;
    localparam logic [1:0] DIV_BY2         = 2'h2;
    localparam logic [1:0] DIV_BY1         = 2'h3;
    localparam logic [1:0] DIV_RST         = 2'h0;
    localparam logic [6:0] CAL_RST_DEFAULT = 7'h40;
    localparam logic [2:0] DIV_CNT_RST     = 3'h0;
endpackage

/* logic/scpm_clock_control.sv */
// system clock selection, divider, and idle/stop/suspend power control
module scpm_clock_control
    import scpm_pkg::*;
#(
    parameter logic [6:0] CAL_RESET = scpm_pkg::CAL_RST_DEFAULT
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_ce,
    // special-function-register bus from the core
    input  wire logic [7:0] i_sfr_addr,
    input  wire logic       i_sfr_wr,
    input  wire logic       i_sfr_rd,
    input  wire logic [7:0] i_sfr_wdata,
    output logic      [7:0] o_sfr_rdata,
    // oscillator tick inputs, synchronous one-cycle enables, plus lf enable and crystal settle levels
    input  wire logic       i_hf_tick,
    input  wire logic       i_ext_tick,
    input  wire logic       i_lf_tick,
    input  wire logic       i_lf_enabled,
    input  wire logic       i_crystal_settled,
    // wake and interrupt events
    input  wire logic       i_port0_match,
    input  wire logic       i_port1_match,
    input  wire logic       i_comp_enabled,
    input  wire logic       i_comp_out,
    input  wire logic       i_timer3_ovf,
    input  wire logic       i_irq_pending,
    // clock enables and status outputs
    output logic            o_system_clock_out,
    output logic            o_cpu_clk_en,
    output logic            o_periph_clk_en,
    output logic            o_ext_timer_clk_en,
    output logic            o_hf_osc_run,
    output logic      [6:0] o_hf_osc_trim,
    output logic            o_crystal_valid_flag,
    output logic            o_idle,
    output logic            o_stop
);
    import scpm_pkg::*;

    logic [5:0] scratch_flags_reg;
    logic       idle_reg;
    logic       stop_reg;
    logic [1:0] clock_source_field_reg;
    logic       hf_en_reg;
    logic       suspend_reg;
    logic [1:0] hf_divider_field_reg;
    logic [6:0] hf_osc_calibration_reg;
    logic [2:0] div_cnt_reg;
    logic       crystal_valid_reg;

    typedef enum logic [1:0] {SCPM_RUN, SCPM_IDLE, SCPM_STOP, SCPM_SUSP}
        scpm_mode_t;
    scpm_mode_t mode_reg;

    // decoded write strobes
    logic wr_pwr, wr_sel, wr_hf, wr_cal, wake_evt;
    assign wr_pwr = i_sfr_wr && (i_sfr_addr == PWR_CTRL_ADDR);
    assign wr_sel = i_sfr_wr && (i_sfr_addr == CLK_SEL_ADDR);
    assign wr_hf  = i_sfr_wr && (i_sfr_addr == HF_CTRL_ADDR);
    assign wr_cal = i_sfr_wr && (i_sfr_addr == HF_CAL_ADDR);
    // any of the four suspend wake sources
    assign wake_evt = i_port0_match || i_port1_match ||
                      (i_comp_enabled && !i_comp_out) || i_timer3_ovf;

    // divide ratio as terminal count, shared by tick and boundary logic
    function automatic logic [2:0] div_last(input logic [1:0] f);
        case (f)
            DIV_BY8: div_last = 3'h7;
            DIV_BY4: div_last = 3'h3;
            DIV_BY2: div_last = 3'h1;
            default: div_last = 3'h0;
        endcase
    endfunction

    // software flags in the top six bits
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            scratch_flags_reg <= SCRATCH_RST;
        end else if (i_ce && wr_pwr) begin
            scratch_flags_reg <= i_sfr_wdata[7:2];
        end
    end

    // power mode machine; stop holds until reset, idle ends on interrupt
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mode_reg <= SCPM_RUN;
        end else if (i_ce) begin
            case (mode_reg)
                SCPM_RUN: begin
                    if (wr_pwr && i_sfr_wdata[PWR_STOP_BIT]) begin
                        mode_reg <= SCPM_STOP;
                    end else if (wr_pwr && i_sfr_wdata[PWR_IDLE_BIT]) begin
                        mode_reg <= SCPM_IDLE;
                    end else if (wr_hf && i_sfr_wdata[HF_SUSP_BIT]) begin
                        mode_reg <= SCPM_SUSP;
                    end
                end
                SCPM_IDLE: begin
                    if (i_irq_pending) begin
                        mode_reg <= SCPM_RUN;
                    end
                end
                SCPM_SUSP: begin
                    if (wake_evt) begin
                        mode_reg <= SCPM_RUN;
                    end
                end
                default: mode_reg <= SCPM_STOP;
            endcase
        end
    end
    assign idle_reg    = (mode_reg == SCPM_IDLE);
    assign stop_reg    = (mode_reg == SCPM_STOP);
    assign suspend_reg = (mode_reg == SCPM_SUSP);

    // clock source select, two writable bits only
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            clock_source_field_reg <= SRC_RST;
        end else if (i_ce && wr_sel) begin
            clock_source_field_reg <= i_sfr_wdata[1:0];
        end
    end

    // hf control: enable and divider; suspend lives in the mode machine
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hf_en_reg            <= 1'b1;
            hf_divider_field_reg <= DIV_RST;
        end else if (i_ce && wr_hf) begin
            hf_en_reg            <= i_sfr_wdata[HF_EN_BIT];
            hf_divider_field_reg <= i_sfr_wdata[1:0];
        end
    end

    // calibration trim; top bit not stored
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hf_osc_calibration_reg <= CAL_RESET;
        end else if (i_ce && wr_cal) begin
            hf_osc_calibration_reg <= i_sfr_wdata[6:0];
        end
    end

    // crystal valid follows the settle detector; software waits 1 ms first
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            crystal_valid_reg <= 1'b0;
        end else if (i_ce) begin
            crystal_valid_reg <= i_crystal_settled;
        end
    end

    // hf post-divider; counts only while the oscillator runs
    logic hf_run;
    assign hf_run = hf_en_reg && !suspend_reg && !stop_reg;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            div_cnt_reg <= DIV_CNT_RST;
        end else if (i_ce && hf_run && i_hf_tick) begin
            // wrap at terminal count, or early if the ratio shrank
            if (div_cnt_reg >= div_last(hf_divider_field_reg)) begin
                div_cnt_reg <= DIV_CNT_RST;
            end else begin
                div_cnt_reg <= div_cnt_reg + 3'h1;
            end
        end
    end

    // selected source tick; hf passes one tick per divided period, but a ratio
    // or source change takes effect at once, so the first period after it can be short
    logic src_tick;
    always_comb begin
        case (clock_source_field_reg)
            SRC_HF:  src_tick = hf_run && i_hf_tick &&
                         (div_cnt_reg >= div_last(hf_divider_field_reg));
            SRC_EXT: src_tick = i_ext_tick;
            SRC_LF:  src_tick = i_lf_enabled && i_lf_tick;
            default: src_tick = 1'b0; // reserved code gives no clock
        endcase
    end

    // registered clock enables for the core and peripherals
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_system_clock_out <= 1'b0;
            o_cpu_clk_en       <= 1'b0;
            o_periph_clk_en    <= 1'b0;
            o_ext_timer_clk_en <= 1'b0;
        end else if (i_ce) begin
            o_system_clock_out <= src_tick && !stop_reg;
            o_cpu_clk_en    <= src_tick && (mode_reg == SCPM_RUN);
            o_periph_clk_en <= src_tick && !stop_reg;
            o_ext_timer_clk_en <= i_ext_tick;
        end
    end

    // registered status mirrors
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_hf_osc_run         <= 1'b1;
            o_hf_osc_trim        <= CAL_RESET;
            o_crystal_valid_flag <= 1'b0;
            o_idle               <= 1'b0;
            o_stop               <= 1'b0;
        end else if (i_ce) begin
            o_hf_osc_run         <= hf_run;
            o_hf_osc_trim        <= hf_osc_calibration_reg;
            o_crystal_valid_flag <= crystal_valid_reg;
            o_idle               <= idle_reg;
            o_stop               <= stop_reg;
        end
    end

    // read mux, one cycle after the read strobe
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_sfr_rdata <= 8'h00;
        end else if (i_ce && i_sfr_rd) begin
            if (i_sfr_addr == PWR_CTRL_ADDR) begin
                o_sfr_rdata <= {scratch_flags_reg, 2'h0};
            end else if (i_sfr_addr == CLK_SEL_ADDR) begin
                o_sfr_rdata <= {6'h00, clock_source_field_reg};
            end else if (i_sfr_addr == HF_CTRL_ADDR) begin
                o_sfr_rdata <= {hf_en_reg, hf_en_reg, suspend_reg,
                                3'h0, hf_divider_field_reg};
            end else if (i_sfr_addr == HF_CAL_ADDR) begin
                o_sfr_rdata <= {1'b0, hf_osc_calibration_reg};
            end else begin
                o_sfr_rdata <= 8'h00;
            end
        end
    end

    // stop is only left by reset
    a_stop_sticky: assert property (@(posedge i_clk) disable iff (i_rst)
        stop_reg |=> stop_reg)
        else $error("stop mode left without reset");
    // idle exits on interrupt within a cycle
    a_idle_exit: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && idle_reg && i_irq_pending) |=> !idle_reg)
        else $error("idle did not end on interrupt");
    // cpu gated in idle
    a_idle_gates: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && idle_reg) |=> !o_cpu_clk_en)
        else $error("cpu clocked while idle");
    // stop write enters stop next cycle
    a_stop_entry: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && mode_reg == SCPM_RUN && wr_pwr && i_sfr_wdata[1])
        |=> stop_reg ##1 !o_hf_osc_run)
        else $error("stop write not honoured");
    // suspend wake
    a_susp_wake: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && suspend_reg && wake_evt) |=> mode_reg == SCPM_RUN)
        else $error("suspend not woken");
    // comparator low wakes only when enabled
    a_comp_wake: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && suspend_reg && !i_port0_match && !i_port1_match &&
         !i_timer3_ovf && (!i_comp_enabled || i_comp_out)) |=> suspend_reg)
        else $error("spurious suspend wake");
    // mode bits read zero
    a_pwr_read: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && i_sfr_rd && i_sfr_addr == PWR_CTRL_ADDR)
        |=> o_sfr_rdata[1:0] == 2'h0)
        else $error("mode bits read nonzero");
    // unused select bits read zero
    a_sel_read: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && i_sfr_rd && i_sfr_addr == CLK_SEL_ADDR)
        |=> o_sfr_rdata[7:2] == 6'h00)
        else $error("unused select bits nonzero");
    // hf tick passes only at divider boundary
    a_div_edge: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && clock_source_field_reg == SRC_HF && i_hf_tick && hf_run &&
         div_cnt_reg < div_last(hf_divider_field_reg))
        |=> !o_system_clock_out)
        else $error("short divided pulse");
    // ext timer clock follows its tick whatever the source
    a_ext_follow: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce
        |=> o_ext_timer_clk_en == $past(i_ext_tick))
        else $error("ext timer clock not following tick");
    // reserved source code gives no system clock
    a_rsvd_src: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && clock_source_field_reg == 2'h3)
        |=> !o_system_clock_out)
        else $error("clock from reserved source");
    // flags read back as last written
    a_flags_rd: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && i_sfr_rd && i_sfr_addr == PWR_CTRL_ADDR)
        |=> o_sfr_rdata[7:2] == $past(scratch_flags_reg))
        else $error("flags read back wrong");
    // calibration top bit reads zero
    a_cal_rd: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && i_sfr_rd && i_sfr_addr == HF_CAL_ADDR)
        |=> !o_sfr_rdata[7])
        else $error("calibration top bit nonzero");
    // suspended hf source clocks neither system nor peripherals
    a_susp_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && suspend_reg && clock_source_field_reg == SRC_HF)
        |=> !o_system_clock_out && !o_periph_clk_en)
        else $error("clock while hf suspended");
    // calibration write reaches the trim output two cycles on
    a_trim_write: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && wr_cal) ##1 i_ce
        |=> o_hf_osc_trim == $past(i_sfr_wdata[6:0], 2))
        else $error("trim not following calibration write");
    // settled crystal shows in the flag two cycles on
    a_xtal_follow: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && i_crystal_settled) ##1 i_ce
        |=> o_crystal_valid_flag)
        else $error("crystal valid flag missed");
    // every reset leaves hf divided by eight as the source
    a_src_reset: assert property (@(posedge i_clk) disable iff (i_rst)
        ($past(i_rst) && $past(i_ce)) |->
        (clock_source_field_reg == SRC_RST &&
         hf_divider_field_reg == DIV_RST))
        else $error("source or divider not reset");
    // divide-by-one passes every hf tick
    a_div_one: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && clock_source_field_reg == SRC_HF && i_hf_tick && hf_run &&
         hf_divider_field_reg == DIV_BY1) |=> o_system_clock_out)
        else $error("divide by one dropped a tick");
    // stop halts cpu, peripheral and system clocks
    a_stop_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && stop_reg)
        |=> !o_cpu_clk_en && !o_periph_clk_en && !o_system_clock_out)
        else $error("clock running in stop");
    // running cpu gets every external source tick
    a_run_cpu: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && mode_reg == SCPM_RUN && clock_source_field_reg == SRC_EXT &&
         i_ext_tick) |=> o_cpu_clk_en)
        else $error("cpu not clocked while running");
endmodule

/* dv/tb_top.sv */
// testbench: register access, clock selection, divider and power modes
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import scpm_pkg::*;
    localparam logic [6:0] CAL_SET = 7'h2B; // arbitrary factory trim
    localparam int XTAL_WAIT = 10000; // 1 ms at a 100 ns clock
    logic       i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_sfr_wr = 1'b0;
    logic       i_sfr_rd = 1'b0, i_hf_tick = 1'b0, i_ext_tick = 1'b0;
    logic       i_lf_tick = 1'b0, i_lf_enabled = 1'b1, i_comp_out = 1'b1;
    logic       i_crystal_settled = 1'b0, i_port0_match = 1'b0;
    logic       i_port1_match = 1'b0, i_comp_enabled = 1'b0;
    logic       i_timer3_ovf = 1'b0, i_irq_pending = 1'b0;
    logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata, d, r;
    logic [6:0] o_hf_osc_trim;
    logic       o_system_clock_out, o_cpu_clk_en, o_periph_clk_en, o_stop;
    logic       o_ext_timer_clk_en, o_hf_osc_run, o_crystal_valid_flag;
    logic       o_idle;
    int         n_mismatch = 0, total_checks = 0, sc, cp, pr, ex, t;
    logic [31:0] seed = 32'd85400;

    always #50 i_clk = ~i_clk;

    scpm_clock_control #(.CAL_RESET(CAL_SET)) i_dut (
        .i_clk                (i_clk),
        .i_rst                (i_rst),
        .i_ce                 (i_ce),
        .i_sfr_addr           (i_sfr_addr),
        .i_sfr_wr             (i_sfr_wr),
        .i_sfr_rd             (i_sfr_rd),
        .i_sfr_wdata          (i_sfr_wdata),
        .o_sfr_rdata          (o_sfr_rdata),
        .i_hf_tick            (i_hf_tick),
        .i_ext_tick           (i_ext_tick),
        .i_lf_tick            (i_lf_tick),
        .i_lf_enabled         (i_lf_enabled),
        .i_crystal_settled    (i_crystal_settled),
        .i_port0_match        (i_port0_match),
        .i_port1_match        (i_port1_match),
        .i_comp_enabled       (i_comp_enabled),
        .i_comp_out           (i_comp_out),
        .i_timer3_ovf         (i_timer3_ovf),
        .i_irq_pending        (i_irq_pending),
        .o_system_clock_out   (o_system_clock_out),
        .o_cpu_clk_en         (o_cpu_clk_en),
        .o_periph_clk_en      (o_periph_clk_en),
        .o_ext_timer_clk_en   (o_ext_timer_clk_en),
        .o_hf_osc_run         (o_hf_osc_run),
        .o_hf_osc_trim        (o_hf_osc_trim),
        .o_crystal_valid_flag (o_crystal_valid_flag),
        .o_idle               (o_idle),
        .o_stop               (o_stop)
    );

    // xorshift keeps the random stream repeatable from the fixed seed
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // a count off by one is tolerated: divider phase is not visible
    function automatic int near(int seen, int e);
        return (seen >= e - 1 && seen <= e + 1) ? e : seen;
    endfunction

    task automatic check(string nm, logic [31:0] seen, logic [31:0] e);
        total_checks++;
        if (seen !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(negedge i_clk);
        i_rst = 1'b1;
        repeat (12) @(negedge i_clk);
        i_rst = 1'b0;
    endtask

    task automatic wr_reg(logic [7:0] a, logic [7:0] v);
        @(negedge i_clk);
        {i_sfr_addr, i_sfr_wdata, i_sfr_wr} = {a, v, 1'b1};
        @(negedge i_clk);
        i_sfr_wr = 1'b0;
    endtask

    // read data is registered, so it is looked at one edge after the strobe
    task automatic rd_reg(logic [7:0] a, output logic [7:0] v);
        @(negedge i_clk);
        {i_sfr_addr, i_sfr_rd} = {a, 1'b1};
        @(negedge i_clk);
        i_sfr_rd = 1'b0;
        v = o_sfr_rdata;
    endtask

    // sel is {hf, ext, lf}: those ticks pulse every cycle for n cycles
    task automatic run_ticks(int n, logic [2:0] sel);
        {sc, cp, pr, ex} = {32'd0, 32'd0, 32'd0, 32'd0};
        for (int k = 0; k < n + 4; k++) begin
            @(negedge i_clk);
            sc += int'(o_system_clock_out === 1'b1);
            cp += int'(o_cpu_clk_en === 1'b1);
            pr += int'(o_periph_clk_en === 1'b1);
            ex += int'(o_ext_timer_clk_en === 1'b1);
            {i_hf_tick, i_ext_tick, i_lf_tick} = (k < n) ? sel : 3'b000;
        end
    endtask

    initial begin
        do_reset();
        rd_reg(PWR_CTRL_ADDR, r); check("pwr_rst", r, 8'h00);
        rd_reg(CLK_SEL_ADDR, r); check("sel_rst", r, 8'h00);
        rd_reg(HF_CTRL_ADDR, r); check("hfctl_rst", r, 8'hC0);
        rd_reg(HF_CAL_ADDR, r); check("cal_rst", r, {1'b0, CAL_SET});
        check("trim_rst", o_hf_osc_trim, CAL_SET);
        rd_reg(8'hA8, r); check("unmapped", r, 8'h00);
        $display("test reset_values done");
        // random register traffic; mode bits kept clear here
        for (int i = 0; i < 8; i++) begin
            d = 8'(xs());
            wr_reg(PWR_CTRL_ADDR, {d[7:2], 2'b00});
            rd_reg(PWR_CTRL_ADDR, r); check("flags", r, {d[7:2], 2'b00});
            wr_reg(CLK_SEL_ADDR, d);
            rd_reg(CLK_SEL_ADDR, r); check("sel", r, {6'h00, d[1:0]});
            wr_reg(HF_CAL_ADDR, d);
            rd_reg(HF_CAL_ADDR, r); check("cal", r, {1'b0, d[6:0]});
            check("trim", o_hf_osc_trim, d[6:0]);
        end
        // clock enable low: a write must leave the register untouched
        i_ce = 1'b0;
        wr_reg(CLK_SEL_ADDR, 8'h02);
        i_ce = 1'b1;
        rd_reg(CLK_SEL_ADDR, r); check("ce_hold", r, {6'h00, d[1:0]});
        $display("test registers done");
        // every divider code, used right after the enabling write
        for (int f = 0; f < 4; f++) begin
            wr_reg(CLK_SEL_ADDR, {6'h00, SRC_HF});
            wr_reg(HF_CTRL_ADDR, 8'h80 | 8'(f));
            run_ticks(64, 3'b100);
            check("hf_div", near(sc, 8 << f), 8 << f);
        end
        // each source code with only the external tick running
        for (int s = 0; s < 4; s++) begin
            wr_reg(CLK_SEL_ADDR, 8'(s));
            run_ticks(40, 3'b010);
            check("src_ext", near(sc, s == 1 ? 40 : 0), s == 1 ? 40 : 0);
            check("ext_timer", ex, 40);
        end
        wr_reg(CLK_SEL_ADDR, {6'h00, SRC_LF});
        run_ticks(40, 3'b001);
        check("src_lf", sc, 40);
        $display("test clock_select done");
        // idle: cpu gated, peripherals alive, bit reads back 0
        wr_reg(CLK_SEL_ADDR, {6'h00, SRC_HF});
        wr_reg(HF_CTRL_ADDR, 8'h83);
        wr_reg(PWR_CTRL_ADDR, 8'hFD);
        repeat (3) @(negedge i_clk);
        check("idle", o_idle, 1'b1);
        rd_reg(PWR_CTRL_ADDR, r); check("idle_rd", r, 8'hFC);
        run_ticks(20, 3'b100);
        check("idle_cpu", cp, 0);
        check("idle_per", near(pr, 20), 20);
        i_irq_pending = 1'b1;
        repeat (3) @(negedge i_clk);
        i_irq_pending = 1'b0;
        check("idle_exit", o_idle, 1'b0);
        $display("test idle done");
        // suspend, woken once by each kind of event
        for (int w = 0; w < 4; w++) begin
            wr_reg(HF_CTRL_ADDR, 8'hA3);
            repeat (3) @(negedge i_clk);
            check("susp_run", o_hf_osc_run, 1'b0);
            check("susp_cpu", o_cpu_clk_en, 1'b0);
            i_comp_enabled = 1'b1; // comparator high must not wake
            repeat (2) @(negedge i_clk);
            check("susp_hold", o_hf_osc_run, 1'b0);
            // hf ticks while suspended must clock nothing
            run_ticks(8, 3'b100);
            check("susp_clk", sc + pr, 0);
            case (w)
                0: i_port0_match = 1'b1;
                1: i_port1_match = 1'b1;
                2: i_comp_out = 1'b0;
                default: i_timer3_ovf = 1'b1;
            endcase
            t = 0;
            while (o_hf_osc_run !== 1'b1 && t < 8) begin
                @(negedge i_clk);
                t++;
            end
            {i_port0_match, i_port1_match, i_timer3_ovf} = 3'b000;
            {i_comp_out, i_comp_enabled} = 2'b10;
            check("wake", o_hf_osc_run, 1'b1);
            if (t == 8) begin
                n_mismatch++;
                close_out();
            end
        end
        $display("test suspend done");
        // stop wins over idle, ignores interrupts, ends only by reset
        wr_reg(CLK_SEL_ADDR, {6'h00, SRC_EXT});
        wr_reg(PWR_CTRL_ADDR, 8'h03);
        i_irq_pending = 1'b1;
        run_ticks(20, 3'b110);
        i_irq_pending = 1'b0;
        check("stop", {o_stop, o_idle, o_hf_osc_run}, 3'b100);
        check("stop_per", pr, 0);
        check("stop_ext", ex, 20);
        rd_reg(PWR_CTRL_ADDR, r); check("stop_rd", r, 8'h00);
        do_reset();
        check("stop_exit", o_stop, 1'b0);
        rd_reg(CLK_SEL_ADDR, r); check("src_rst", r, 8'h00);
        $display("test stop done");
        check("xtal_rst", o_crystal_valid_flag, 1'b0);
        // software waits 1 ms after enabling before it polls the flag
        i_crystal_settled = 1'b1;
        repeat (XTAL_WAIT) @(negedge i_clk);
        check("xtal", o_crystal_valid_flag, 1'b1);
        $display("test crystal done");
        close_out();
    end
endmodule
